// ### pkg/vfp_pkg.sv
package vfp_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int LANES = 4;
  localparam int LANE_W = 32;
  localparam int VEC_W = LANES * LANE_W;

  // ==========================================================================
  // Operations
  // ==========================================================================
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MAX = 4'h2, OP_MIN = 4'h3,
    OP_MADD = 4'h4, OP_NMSUB = 4'h5, OP_RNEAR = 4'h6, OP_RZERO = 4'h7,
    OP_RDOWN = 4'h8, OP_RUP = 4'h9, OP_TRUNC_U = 4'hA, OP_TRUNC_S = 4'hB,
    OP_RECIP = 4'hC
  } op_t;

  // Sub-operation of the conversion unit, in the same order as the operations.
  typedef enum logic [2:0] {
    CV_NEAR = 3'h0, CV_ZERO = 3'h1, CV_DOWN = 3'h2, CV_UP = 3'h3,
    CV_UINT = 3'h4, CV_SINT = 3'h5, CV_RECIP = 3'h6
  } conv_t;

  // ==========================================================================
  // Encodings and exponent thresholds
  // ==========================================================================
  localparam logic [31:0] QNAN = 32'h7FC00000;
  localparam logic [31:0] ONE = 32'h3F800000;
  localparam logic [31:0] QUIET = 32'h00400000;
  localparam logic [31:0] SIGN_BIT = 32'h80000000;
  localparam logic [31:0] SAT_S_POS = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_U = 32'hFFFFFFFF;
  localparam logic [7:0] EXP_ONES = 8'hFF;
  localparam logic [7:0] EXP_BIAS = 8'h7F;
  localparam logic [7:0] EXP_HALF = 8'h7E;
  localparam logic [7:0] EXP_INT = 8'h96;
  localparam logic [7:0] EXP_S_SAT = 8'h9E;
  localparam logic [7:0] EXP_U_SAT = 8'h9F;
  localparam logic [7:0] EXP_WIDE = 8'hB6;
  localparam logic [7:0] EXP_RCP = 8'hFD;
  localparam logic [7:0] EXP_RCP_MAX = 8'hFE;

  // Fused datapath alignment: addend key offset, normalise offset, shift limit.
  localparam logic [9:0] ADD_KEY = 10'h07E;
  localparam logic [11:0] NORM_OFS = 12'h07D;
  localparam logic [11:0] ALIGN_LIM = 12'h034;
  localparam logic [11:0] EXP_OVF = 12'h0FF;

  // ==========================================================================
  // Field helpers
  // ==========================================================================
  function automatic logic is_nan(input logic [31:0] x);
    return (x[30:23] == EXP_ONES) && (x[22:0] != 23'h0);
  endfunction

  function automatic logic is_inf(input logic [31:0] x);
    return (x[30:23] == EXP_ONES) && (x[22:0] == 23'h0);
  endfunction

  function automatic logic [31:0] quiet(input logic [31:0] x);
    return x | QUIET;
  endfunction

  // Denormals use the smallest normal exponent with no hidden bit.
  function automatic logic [7:0] exp_of(input logic [31:0] x);
    return (x[30:23] == 8'h00) ? 8'h01 : x[30:23];
  endfunction

  function automatic logic [23:0] mant_of(input logic [31:0] x);
    return {x[30:23] != 8'h00, x[22:0]};
  endfunction

endpackage

// ### pkg/fp_unit_if.sv
`timescale 1ns/10ps
// ============================================================================
// Lane operand bundle between the datapath and its helper units
// ============================================================================
interface fp_unit_if;
  logic [31:0] a;
  logic [31:0] b;
  logic [2:0] mode;
  logic [31:0] res;
  modport src (output a, b, mode, input res);
  modport unit (input a, b, mode, output res);
endinterface

// ### hdl/fp_minmax.sv
`timescale 1ns/10ps
// ============================================================================
// Maximum and minimum of one lane
// ============================================================================
module fp_minmax (
  fp_unit_if.unit unit_bus // Operands in, chosen value out; mode bit 0 selects minimum.
);

  logic a_above;

  // Negative values invert so that an unsigned compare orders them; -0.0 lands just below +0.0.
  function automatic logic [31:0] order_key(input logic [31:0] x);
    return x[31] ? ~x : (x | vfp_pkg::SIGN_BIT);
  endfunction

  // A NaN on either side always yields a quiet NaN; otherwise the ordered key decides.
  always_comb begin
    a_above = order_key(unit_bus.a) > order_key(unit_bus.b);
    if (vfp_pkg::is_nan(unit_bus.a)) begin
      unit_bus.res = vfp_pkg::quiet(unit_bus.a);
    end else if (vfp_pkg::is_nan(unit_bus.b)) begin
      unit_bus.res = vfp_pkg::quiet(unit_bus.b);
    end else if (unit_bus.mode[0]) begin
      unit_bus.res = a_above ? unit_bus.b : unit_bus.a;
    end else begin
      unit_bus.res = a_above ? unit_bus.a : unit_bus.b;
    end
  end

endmodule

// ### hdl/fp_convert.sv
`timescale 1ns/10ps
// ============================================================================
// Round to integral, truncating conversion and reciprocal estimate
// ============================================================================
module fp_convert (
  fp_unit_if.unit unit_bus // Source in a, sub-operation in mode, result out.
);

  logic sgn;
  logic [7:0] ex;
  logic [22:0] fr;
  logic [23:0] man;
  logic [4:0] nfr;
  logic [23:0] rem;
  logic [23:0] half;
  logic up;
  logic [55:0] wide;

  // One combinational unit; every sub-operation shares the field split.
  always_comb begin
    sgn = unit_bus.a[31];
    ex = unit_bus.a[30:23];
    fr = unit_bus.a[22:0];
    man = vfp_pkg::mant_of(unit_bus.a);
    nfr = 5'(vfp_pkg::EXP_INT - ex);
    rem = man & ~(24'hFFFFFF << nfr);
    half = 24'h000001 << (nfr - 5'h01);
    wide = {man, 32'h00000000} >> (vfp_pkg::EXP_WIDE - ex);
    up = 1'b0;
    unit_bus.res = 32'h00000000;
    case (unit_bus.mode)
      vfp_pkg::CV_NEAR, vfp_pkg::CV_ZERO, vfp_pkg::CV_DOWN, vfp_pkg::CV_UP: begin
        if (vfp_pkg::is_nan(unit_bus.a)) begin
          unit_bus.res = vfp_pkg::quiet(unit_bus.a);
        end else if (ex >= vfp_pkg::EXP_INT) begin
          unit_bus.res = unit_bus.a;
        end else if (ex < vfp_pkg::EXP_BIAS) begin
          // Below one: the answer is a signed zero or a signed one.
          unit_bus.res = {sgn, 31'h00000000};
          if (unit_bus.mode == vfp_pkg::CV_NEAR && ex == vfp_pkg::EXP_HALF && fr != 23'h0) begin
            unit_bus.res = {sgn, vfp_pkg::ONE[30:0]};
          end else if (unit_bus.mode == vfp_pkg::CV_DOWN && sgn && unit_bus.a[30:0] != 31'h0) begin
            unit_bus.res = {sgn, vfp_pkg::ONE[30:0]};
          end else if (unit_bus.mode == vfp_pkg::CV_UP && !sgn && unit_bus.a[30:0] != 31'h0) begin
            unit_bus.res = vfp_pkg::ONE;
          end
        end else begin
          // Clear the fraction bits and carry into the exponent when rounding away.
          case (unit_bus.mode)
            vfp_pkg::CV_NEAR: up = (rem > half) || (rem == half && man[nfr]);
            vfp_pkg::CV_DOWN: up = sgn && rem != 24'h0;
            vfp_pkg::CV_UP: up = !sgn && rem != 24'h0;
            default: up = 1'b0;
          endcase
          unit_bus.res = {sgn, {ex, fr & (23'h7FFFFF << nfr)} + ({30'h0, up} << nfr)};
        end
      end
      vfp_pkg::CV_UINT: begin
        // Truncation only; NaN and negatives give zero, large values saturate.
        if (vfp_pkg::is_nan(unit_bus.a) || sgn || ex < vfp_pkg::EXP_BIAS) begin
          unit_bus.res = 32'h00000000;
        end else if (ex >= vfp_pkg::EXP_U_SAT) begin
          unit_bus.res = vfp_pkg::SAT_U;
        end else begin
          unit_bus.res = wide[31:0];
        end
      end
      vfp_pkg::CV_SINT: begin
        if (vfp_pkg::is_nan(unit_bus.a) || ex < vfp_pkg::EXP_BIAS) begin
          unit_bus.res = 32'h00000000;
        end else if (ex >= vfp_pkg::EXP_S_SAT) begin
          unit_bus.res = sgn ? vfp_pkg::SIGN_BIT : vfp_pkg::SAT_S_POS;
        end else begin
          unit_bus.res = sgn ? 32'(-wide[31:0]) : wide[31:0];
        end
      end
      vfp_pkg::CV_RECIP: begin
        // Coarse estimate; tiny denormals and zeros overflow to a signed infinity.
        if (vfp_pkg::is_nan(unit_bus.a)) begin
          unit_bus.res = vfp_pkg::quiet(unit_bus.a);
        end else if (ex == vfp_pkg::EXP_ONES || ex >= vfp_pkg::EXP_RCP_MAX) begin
          unit_bus.res = {sgn, 31'h00000000};
        end else if (ex == 8'h00 && !fr[22]) begin
          unit_bus.res = {sgn, vfp_pkg::EXP_ONES, 23'h0};
        end else if (ex == 8'h00) begin
          unit_bus.res = {sgn, vfp_pkg::EXP_RCP, ~fr[21:0], 1'b1};
        end else begin
          unit_bus.res = {sgn, 8'(vfp_pkg::EXP_RCP - ex), ~fr};
        end
      end
      default: unit_bus.res = 32'h00000000;
    endcase
  end

endmodule

// ### hdl/vfp_datapath.sv
`timescale 1ns/10ps
module vfp_datapath (
  input wire logic I_CLOCK, // Core clock.
  input wire logic I_RST_N, // Synchronous reset, active low.
  input wire logic I_VALID, // Operation issued this cycle.
  input wire vfp_pkg::op_t I_OP, // Operation select.
  input wire logic [vfp_pkg::VEC_W-1:0] I_SRC_A, // First source, multiplicand.
  input wire logic [vfp_pkg::VEC_W-1:0] I_SRC_B, // Second source, addend or unary source.
  input wire logic [vfp_pkg::VEC_W-1:0] I_SRC_C, // Third source, multiplier.
  output logic O_VALID, // Result valid one cycle after issue.
  output logic [vfp_pkg::VEC_W-1:0] O_RESULT // Registered result vector.
);

  // ==========================================================================
  // Operation decode
  // ==========================================================================
  logic fused;
  logic neg_add;
  logic neg_res;
  logic [vfp_pkg::VEC_W-1:0] lanes_w;
  logic [vfp_pkg::VEC_W-1:0] result_d;
  logic [vfp_pkg::VEC_W-1:0] result_q;
  logic valid_d;
  logic valid_q;

  // Add and subtract run through the fused path with a multiplier of exactly one.
  assign fused = (I_OP == vfp_pkg::OP_MADD) || (I_OP == vfp_pkg::OP_NMSUB);
  assign neg_add = (I_OP == vfp_pkg::OP_SUB) || (I_OP == vfp_pkg::OP_NMSUB);
  assign neg_res = (I_OP == vfp_pkg::OP_NMSUB);

  // Leading zero count of the aligned sum.
  function automatic logic [5:0] lead_zeros(input logic [51:0] v);
    logic found;
    found = 1'b0;
    lead_zeros = 6'h34;
    for (int i = 51; i >= 0; i--) begin
      if (!found && v[i]) begin
        found = 1'b1;
        lead_zeros = 6'(51 - i);
      end
    end
  endfunction

  // ==========================================================================
  // Lanes
  // ==========================================================================
  for (genvar l = 0; l < vfp_pkg::LANES; l++) begin : g_lane
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] fm;
    logic [31:0] fb;
    logic [31:0] fma_res;
    logic [31:0] lane_res;
    logic sp;
    logic hs;
    logic ls;
    logic eff_sub;
    logic rs;
    logic inc;
    logic st2;
    logic zp;
    logic inf_p;
    logic [47:0] prod;
    logic [9:0] pkey;
    logic [9:0] bkey;
    logic [9:0] big_key;
    logic [9:0] dlt;
    logic [51:0] hi;
    logic [51:0] lo;
    logic [51:0] lo_j;
    logic [51:0] mag;
    logic [51:0] norm;
    logic [5:0] lz;
    logic [11:0] exps;
    logic [11:0] sh;
    logic [30:0] rnd_word;

    // Each lane sees only its own slice of every source.
    assign a = I_SRC_A[l*vfp_pkg::LANE_W +: vfp_pkg::LANE_W];
    assign b = I_SRC_B[l*vfp_pkg::LANE_W +: vfp_pkg::LANE_W];
    assign c = I_SRC_C[l*vfp_pkg::LANE_W +: vfp_pkg::LANE_W];

    fp_unit_if mm_if ();
    fp_unit_if cv_if ();

    // Helper units are purely combinational and share the lane operands.
    assign mm_if.a = a;
    assign mm_if.b = b;
    assign mm_if.mode = {2'b00, I_OP == vfp_pkg::OP_MIN};
    assign cv_if.a = b;
    assign cv_if.b = 32'h00000000;
    assign cv_if.mode = 3'(I_OP - vfp_pkg::OP_RNEAR);

    fp_minmax u_minmax (
      .unit_bus(mm_if)
    );

    fp_convert u_convert (
      .unit_bus(cv_if)
    );

    // Fused multiply-add: exact 48-bit product, one alignment, one rounding to nearest even.
    always_comb begin
      fm = fused ? c : vfp_pkg::ONE;
      fb = {b[31] ^ neg_add, b[30:0]};
      sp = a[31] ^ fm[31];
      prod = vfp_pkg::mant_of(a) * vfp_pkg::mant_of(fm);
      zp = (prod == 48'h0);
      // A zero operand gets the lowest key so it never pushes the other one into the sticky bit.
      pkey = zp ? 10'h000 : {2'b00, vfp_pkg::exp_of(a)} + {2'b00, vfp_pkg::exp_of(fm)};
      bkey = (vfp_pkg::mant_of(fb) == 24'h0) ? 10'h000 : {2'b00, vfp_pkg::exp_of(fb)} + vfp_pkg::ADD_KEY;
      if (pkey >= bkey) begin
        big_key = pkey;
        dlt = pkey - bkey;
        hi = {1'b0, prod, 3'b000};
        lo = {1'b0, vfp_pkg::mant_of(fb), 27'h0};
        hs = sp;
        ls = fb[31];
      end else begin
        big_key = bkey;
        dlt = bkey - pkey;
        hi = {1'b0, vfp_pkg::mant_of(fb), 27'h0};
        lo = {1'b0, prod, 3'b000};
        hs = fb[31];
        ls = sp;
      end
      // Bits shifted past the bottom jam into bit 0 so the sticky survives subtraction.
      if ({2'b00, dlt} >= vfp_pkg::ALIGN_LIM) begin
        lo_j = {51'h0, |lo};
      end else begin
        lo_j = lo >> dlt;
        lo_j[0] = lo_j[0] | (|(lo & ~({52{1'b1}} << dlt)));
      end
      eff_sub = hs ^ ls;
      if (!eff_sub) begin
        mag = hi + lo_j;
        rs = hs;
      end else if (hi >= lo_j) begin
        mag = hi - lo_j;
        rs = hs;
      end else begin
        mag = lo_j - hi;
        rs = ls;
      end
      lz = lead_zeros(mag);
      norm = mag << lz;
      exps = {2'b00, big_key} - vfp_pkg::NORM_OFS - {6'h00, lz};
      st2 = 1'b0;
      sh = 12'h000;
      // Results below the normal range are shifted down into a denormal, not flushed.
      if (exps[11] || exps == 12'h000) begin
        sh = 12'h001 - exps;
        if (sh >= vfp_pkg::ALIGN_LIM) begin
          st2 = |norm;
          norm = 52'h0;
        end else begin
          st2 = |(norm & ~({52{1'b1}} << sh));
          norm = norm >> sh;
        end
        exps = 12'h000;
      end
      // The only rounding step: nearest, ties to even; a carry ripples into the exponent.
      inc = norm[27] & (norm[28] | (|norm[26:0]) | st2);
      rnd_word = {exps[7:0], norm[50:28]} + {30'h0, inc};
      inf_p = vfp_pkg::is_inf(a) || vfp_pkg::is_inf(fm);
      // Special operands take precedence; each gives its default value with no flag.
      if (vfp_pkg::is_nan(a)) begin
        fma_res = vfp_pkg::quiet(a);
      end else if (vfp_pkg::is_nan(b)) begin
        fma_res = vfp_pkg::quiet(b);
      end else if (vfp_pkg::is_nan(fm)) begin
        fma_res = vfp_pkg::quiet(fm);
      end else if (inf_p && zp) begin
        fma_res = vfp_pkg::QNAN;
      end else if (inf_p && vfp_pkg::is_inf(fb) && sp != fb[31]) begin
        fma_res = vfp_pkg::QNAN;
      end else if (inf_p) begin
        fma_res = {sp, vfp_pkg::EXP_ONES, 23'h0};
      end else if (vfp_pkg::is_inf(fb)) begin
        fma_res = {fb[31], vfp_pkg::EXP_ONES, 23'h0};
      end else if (mag == 52'h0) begin
        // An exact zero sum is +0.0 unless both terms were zeros of the same negative sign.
        fma_res = {eff_sub ? 1'b0 : hs, 31'h00000000};
      end else if (!exps[11] && exps >= vfp_pkg::EXP_OVF) begin
        fma_res = {rs, vfp_pkg::EXP_ONES, 23'h0};
      end else begin
        fma_res = {rs, rnd_word};
      end
      // The final negation leaves a NaN untouched.
      if (neg_res && !vfp_pkg::is_nan(fma_res)) begin
        fma_res[31] = ~fma_res[31];
      end
    end

    // Lane result steering by operation class.
    always_comb begin
      case (I_OP)
        vfp_pkg::OP_ADD, vfp_pkg::OP_SUB: lane_res = fma_res;
        vfp_pkg::OP_MADD, vfp_pkg::OP_NMSUB: lane_res = fma_res;
        vfp_pkg::OP_MAX, vfp_pkg::OP_MIN: lane_res = mm_if.res;
        default: lane_res = cv_if.res;
      endcase
    end

    assign lanes_w[l*vfp_pkg::LANE_W +: vfp_pkg::LANE_W] = lane_res;
  end

  // ==========================================================================
  // Result register
  // ==========================================================================
  // The result is captured on issue and held until the next issue, so the register file
  // may take it any time before then.
  always_comb begin
    valid_d = I_VALID;
    result_d = I_VALID ? lanes_w : result_q;
  end

  // Registers only; reset clears both the strobe and the held data.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      valid_q <= 1'b0;
      result_q <= '0;
    end else begin
      valid_q <= valid_d;
      result_q <= result_d;
    end
  end

  assign O_VALID = valid_q;
  assign O_RESULT = result_q;

endmodule

// ### bench/vfp_datapath_monitor.sv
`timescale 1ns/10ps
// ============================================================================
// Port checker for the vector datapath, watching lane 0
// ============================================================================
module vfp_datapath_monitor (
  input wire logic I_CLOCK, // Core clock.
  input wire logic I_RST_N, // Synchronous reset, active low.
  input wire logic I_VALID, // Issue strobe.
  input wire vfp_pkg::op_t I_OP, // Operation select.
  input wire logic [vfp_pkg::VEC_W-1:0] I_SRC_A, // First source.
  input wire logic [vfp_pkg::VEC_W-1:0] I_SRC_B, // Second source.
  input wire logic [vfp_pkg::VEC_W-1:0] I_SRC_C, // Third source.
  input wire logic O_VALID, // Result strobe.
  input wire logic [vfp_pkg::VEC_W-1:0] O_RESULT // Result vector.
);
  logic [31:0] a0;
  logic [31:0] b0;
  logic [31:0] r0;
  // Lane 0 only; the bench rotates its cases across lanes to judge the other three.
  assign a0 = I_SRC_A[31:0];
  assign b0 = I_SRC_B[31:0];
  assign r0 = O_RESULT[31:0];
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_answer;
    I_VALID |=> O_VALID;
  endproperty
  property p_idle;
    !I_VALID |=> !O_VALID && $stable(O_RESULT);
  endproperty
  property p_add_inf;
    I_VALID && I_OP == vfp_pkg::OP_ADD && a0[30:0] == 31'h7F800000 && b0 == (a0 ^ 32'h80000000)
      |=> r0 == 32'h7FC00000;
  endproperty
  property p_max_zero;
    I_VALID && I_OP == vfp_pkg::OP_MAX && a0[30:0] == 31'h0 && b0[30:0] == 31'h0
      |=> r0 == {$past(a0[31] & b0[31]), 31'h0};
  endproperty
  property p_min_zero;
    I_VALID && I_OP == vfp_pkg::OP_MIN && a0[30:0] == 31'h0 && b0[30:0] == 31'h0
      |=> r0 == {$past(a0[31] | b0[31]), 31'h0};
  endproperty
  property p_mm_nan;
    I_VALID && (I_OP == vfp_pkg::OP_MAX || I_OP == vfp_pkg::OP_MIN) &&
      ((a0[30:23] == 8'hFF && a0[22:0] != 23'h0) || (b0[30:23] == 8'hFF && b0[22:0] != 23'h0))
      |=> r0[30:22] == 9'h1FF;
  endproperty
  property p_nmsub_nan;
    I_VALID && I_OP == vfp_pkg::OP_NMSUB && a0[30:22] == 9'h1FF |=> r0 == $past(a0);
  endproperty
  property p_rint_big;
    I_VALID && I_OP >= vfp_pkg::OP_RNEAR && I_OP <= vfp_pkg::OP_RUP && b0[30:23] >= 8'h96 &&
      b0[30:23] != 8'hFF |=> r0 == $past(b0);
  endproperty
  property p_trunc_neg;
    I_VALID && I_OP == vfp_pkg::OP_TRUNC_U && b0[31] |=> r0 == 32'h0;
  endproperty
  property p_recip_tiny;
    I_VALID && I_OP == vfp_pkg::OP_RECIP && b0[30:22] == 9'h0 |=> r0 == {$past(b0[31]), 31'h7F800000};
  endproperty
  // ==========================================================================
  // Assertions and covers
  // ==========================================================================
  a_answer: assert property (p_answer) else $error("issue without result");
  a_idle: assert property (p_idle) else $error("result moved without issue");
  a_add_inf: assert property (p_add_inf) else $error("opposite infinities not default NaN");
  a_max_zero: assert property (p_max_zero) else $error("max of zeros has wrong sign");
  a_min_zero: assert property (p_min_zero) else $error("min of zeros has wrong sign");
  a_mm_nan: assert property (p_mm_nan) else $error("max or min of NaN not quiet NaN");
  a_nmsub_nan: assert property (p_nmsub_nan) else $error("negated multiply NaN altered");
  a_rint_big: assert property (p_rint_big) else $error("integral value changed");
  a_trunc_neg: assert property (p_trunc_neg) else $error("unsigned truncate of negative");
  a_recip_tiny: assert property (p_recip_tiny) else $error("tiny reciprocal not infinite");
  c_back_to_back: cover property (I_VALID [*2]);
  c_max_zero: cover property (I_VALID && I_OP == vfp_pkg::OP_MAX && a0[30:0] == 31'h0 && b0[30:0] == 31'h0);
  c_nmsub_nan: cover property (I_VALID && I_OP == vfp_pkg::OP_NMSUB && a0[30:22] == 9'h1FF);
endmodule
bind vfp_datapath vfp_datapath_monitor vfp_datapath_monitor_i (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_VALID(I_VALID), .I_OP(I_OP), .I_SRC_A(I_SRC_A), .I_SRC_B(I_SRC_B), .I_SRC_C(I_SRC_C),
  .O_VALID(O_VALID), .O_RESULT(O_RESULT));

// ### bench/issue_model.sv
`timescale 1ns/10ps
// ============================================================================
// Issue logic model: launches operations and notes what each must return
// ============================================================================
module issue_model (
  input wire logic i_clk, // Core clock.
  output logic o_valid, // Issue strobe.
  output vfp_pkg::op_t o_op, // Operation select.
  output logic [vfp_pkg::VEC_W-1:0] o_src_a, // First source.
  output logic [vfp_pkg::VEC_W-1:0] o_src_b, // Second source.
  output logic [vfp_pkg::VEC_W-1:0] o_src_c // Third source.
);
  logic [vfp_pkg::VEC_W-1:0] exp_q[$]; // Expected results, oldest first.
  // Nothing is issued until the first send.
  initial begin
    o_valid = 1'b0;
    o_op = vfp_pkg::OP_ADD;
    o_src_a = '0;
    o_src_b = '0;
    o_src_c = '0;
  end
  // One issue per call, held until the next edge takes it; calls in a row give back-to-back issues.
  task automatic send(input vfp_pkg::op_t op, input logic [vfp_pkg::VEC_W-1:0] a, b, c, e);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_op = op;
    o_src_a = a;
    o_src_b = b;
    o_src_c = c;
    exp_q.push_back(e);
  endtask
  // Idle cycles scramble every operand, so a result that follows its inputs without an issue shows.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1;
      o_valid = 1'b0;
      o_op = vfp_pkg::op_t'($urandom_range(15));
      o_src_a = {4{$urandom()}};
      o_src_b = {4{$urandom()}};
      o_src_c = {4{$urandom()}};
    end
  endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end
// ============================================================================
// Bench top: clock, reset, table-driven issue and result scoreboard
// ============================================================================
module tb_top;
  typedef struct {logic [3:0] op; logic [31:0] a; logic [31:0] b; logic [31:0] c; logic [31:0] e;} row_t;
  logic clk;
  logic rst_n;
  logic vld;
  vfp_pkg::op_t op;
  logic [vfp_pkg::VEC_W-1:0] src_a;
  logic [vfp_pkg::VEC_W-1:0] src_b;
  logic [vfp_pkg::VEC_W-1:0] src_c;
  logic res_vld;
  logic [vfp_pkg::VEC_W-1:0] result;
  logic [vfp_pkg::VEC_W-1:0] exp_v;
  int err_total;
  int compares;
  row_t rows[$];
  issue_model issue_model_i (.i_clk(clk), .o_valid(vld), .o_op(op), .o_src_a(src_a), .o_src_b(src_b),
    .o_src_c(src_c));
  vfp_datapath vfp_datapath_i (.I_CLOCK(clk), .I_RST_N(rst_n), .I_VALID(vld), .I_OP(op), .I_SRC_A(src_a),
    .I_SRC_B(src_b), .I_SRC_C(src_c), .O_VALID(res_vld), .O_RESULT(result));
  // 100 MHz core clock.
  initial begin
    clk = 1'b0;
    forever begin
      #5 clk = ~clk;
    end
  end
  // Results are taken at the falling edge, well clear of the edge that registers them.
  always @(negedge clk) begin
    if (rst_n === 1'b1 && res_vld === 1'b1) begin
      if (issue_model_i.exp_q.size() == 0) begin
        `CHK("O_VALID", 1'b0, res_vld)
      end else begin
        exp_v = issue_model_i.exp_q.pop_front();
        `CHK("O_RESULT", exp_v, result)
      end
    end
  end
  task automatic r(input logic [3:0] o, input logic [31:0] a, b, c, e);
    rows.push_back('{o, a, b, c, e});
  endtask
  task automatic u(input logic [3:0] o, input logic [31:0] b, e);
    rows.push_back('{o, 32'h0, b, 32'h0, e});
  endtask
  // Each operation gets four lanes built from its cases, rotated so each case visits other lanes.
  task automatic run_pass(input int rot_fix);
    row_t sel[$];
    logic [vfp_pkg::VEC_W-1:0] va, vb, vc, ve;
    int rot;
    int j;
    for (int k = 0; k < 14; k++) begin
      sel = rows.find(x) with (x.op == k[3:0]);
      rot = (rot_fix < 0) ? int'($urandom_range(3)) : rot_fix;
      for (int l = 0; l < 4; l++) begin
        j = (l + rot) % sel.size();
        va[32*l +: 32] = (k >= 6) ? $urandom() : sel[j].a;
        vb[32*l +: 32] = sel[j].b;
        vc[32*l +: 32] = (k == 4 || k == 5) ? sel[j].c : $urandom();
        ve[32*l +: 32] = sel[j].e;
      end
      issue_model_i.send(vfp_pkg::op_t'(k), va, vb, vc, ve);
      issue_model_i.idle($urandom_range(2));
    end
  endtask
  // Every outstanding result must arrive within a few cycles.
  task automatic drain();
    for (int w = 0; w < 8 && issue_model_i.exp_q.size() > 0; w++) begin
      @(posedge clk);
    end
    if (issue_model_i.exp_q.size() > 0) begin
      err_total++;
      $display("ERROR pending results expected 0 seen %0d", issue_model_i.exp_q.size());
      close_out();
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Lane cases: operation, A, B, C, expected; unary operations read B only.
  initial begin
    err_total = 0;
    compares = 0;
    rst_n = 1'b0;
    void'($urandom(32'hB80B4742));
    r(4'h0, 32'h7F800000, 32'hFF800000, 32'h0, 32'h7FC00000);
    r(4'h0, 32'h3F800000, 32'h3F800000, 32'h0, 32'h40000000);
    r(4'h0, 32'h00000000, 32'h80000000, 32'h0, 32'h00000000);
    r(4'h0, 32'h3F800001, 32'h33800000, 32'h0, 32'h3F800002);
    r(4'h1, 32'h40400000, 32'h3F800000, 32'h0, 32'h40000000);
    r(4'h1, 32'h7F7FFFFF, 32'hFF7FFFFF, 32'h0, 32'h7F800000);
    r(4'h1, 32'h80000000, 32'h00000000, 32'h0, 32'h80000000);
    r(4'h2, 32'h00000000, 32'h80000000, 32'h0, 32'h00000000);
    r(4'h2, 32'h7F800001, 32'h3F800000, 32'h0, 32'h7FC00001);
    r(4'h2, 32'h3F800000, 32'hC0000000, 32'h0, 32'h3F800000);
    r(4'h2, 32'h80000000, 32'h80000000, 32'h0, 32'h80000000);
    r(4'h3, 32'h00000000, 32'h80000000, 32'h0, 32'h80000000);
    r(4'h3, 32'h3F800000, 32'hFF800001, 32'h0, 32'hFFC00001);
    r(4'h3, 32'hBF800000, 32'h3F800000, 32'h0, 32'hBF800000);
    r(4'h3, 32'h00000000, 32'h00000000, 32'h0, 32'h00000000);
    r(4'h4, 32'h3F800001, 32'hBF800002, 32'h3F800001, 32'h28800000);
    r(4'h4, 32'h7F800000, 32'h3F800000, 32'h00000000, 32'h7FC00000);
    r(4'h4, 32'h3F800000, 32'h3F800000, 32'h40000000, 32'h40400000);
    r(4'h5, 32'hFFC00000, 32'h00000000, 32'h3F800000, 32'hFFC00000);
    r(4'h5, 32'h3F800001, 32'h3F800002, 32'h3F800001, 32'hA8800000);
    r(4'h5, 32'h3F800000, 32'h3F800000, 32'h40000000, 32'hBF800000);
    u(4'h6, 32'h4B000001, 32'h4B000001);
    u(4'h6, 32'h3FC00000, 32'h40000000);
    u(4'h6, 32'h40200000, 32'h40000000);
    u(4'h6, 32'hBEB33333, 32'h80000000);
    u(4'h7, 32'hBFC00000, 32'hBF800000);
    u(4'h7, 32'h3F000000, 32'h00000000);
    u(4'h8, 32'hBFC00000, 32'hC0000000);
    u(4'h8, 32'h3E99999A, 32'h00000000);
    u(4'h9, 32'hBE99999A, 32'h80000000);
    u(4'h9, 32'h3E99999A, 32'h3F800000);
    u(4'hA, 32'hBF800000, 32'h00000000);
    u(4'hA, 32'h40600000, 32'h00000003);
    u(4'hA, 32'h4F800000, 32'hFFFFFFFF);
    u(4'hB, 32'hC0600000, 32'hFFFFFFFD);
    u(4'hB, 32'h4F000000, 32'h7FFFFFFF);
    u(4'hB, 32'hCF800000, 32'h80000000);
    u(4'hC, 32'h00000001, 32'h7F800000);
    u(4'hC, 32'h80000001, 32'hFF800000);
    u(4'hC, 32'h7F800000, 32'h00000000);
    u(4'hD, 32'h3F800000, 32'h00000000);
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    run_pass(0);
    run_pass(1);
    issue_model_i.idle(1);
    drain();
    // A reset in mid-run must leave the datapath ready for the next issue.
    @(posedge clk);
    #1 rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("O_RESULT", '0, result)
    `CHK("O_VALID", 1'b0, res_vld)
    run_pass(-1);
    issue_model_i.idle(1);
    drain();
    close_out();
  end
endmodule
